// File: design/ulms_cfg.svh
/*
  Offsets, field positions and reset values of the line and modem status block.
  Assumes a classic Wishbone slave with 32-bit data, one register per aligned word.
*/
`ifndef ULMS_CFG_SVH
`define ULMS_CFG_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define ULMS_ADR_LINE_STATUS 8'h00
`define ULMS_ADR_MODEM_STATUS 8'h04
`define ULMS_ADR_MODEM_CONTROL 8'h08
`define ULMS_ADR_IRQ_STATUS 8'h0C
`define ULMS_ADR_IRQ_CLEAR 8'h10
`define ULMS_ADR_IRQ_ENABLE 8'h14
`define ULMS_ADR_RX_DATA 8'h18

// ************************************************************
// Field positions
// ************************************************************
`define ULMS_LS_READY 0
`define ULMS_LS_OVERRUN 1
`define ULMS_MC_DTR 0
`define ULMS_MC_RTS 1
`define ULMS_MC_OUT1 2
`define ULMS_MC_OUT2 3
`define ULMS_MC_LOOP 4
`define ULMS_IRQ_MODEM 0
`define ULMS_IRQ_OVERRUN 1
`define ULMS_IRQ_READY 2

// ************************************************************
// Reset values and read data of unmapped addresses
// ************************************************************
`define ULMS_RST_MODEM_CONTROL 5'h00
`define ULMS_RST_IRQ_ENABLE 3'h0
`define ULMS_UNMAPPED_DATA 32'h0000_0000

`endif

// File: design/ulms_pkg.sv
/*
  Types of the line and modem status block.
  Assumes ulms_cfg.svh for all numeric constants.
*/
package ulms_pkg;

  // Modem inputs, active low as on the pins
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } ulms_modem_in_s;

  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ulms_wb_req_s;

endpackage

// File: design/ulms_status.sv
/*
  Line status overrun and data-ready flags, modem status register with change
  flags and loop-back, modem control register, interrupt status, enable and clear.
  Assumes a classic Wishbone master and a receiver that pulses rx_done_i with
  rx_char_i when a character completes in the shift register.
*/
`timescale 1ns/1ns
`default_nettype none

`include "ulms_cfg.svh"

// Contract
// - Overrun flag sets when a character completes while the receive FIFO is full.
// - On overrun the new character is dropped; FIFO contents stay intact.
// - Data-ready is high while the FIFO holds at least one character.
// - Data-ready is low when the FIFO is empty, also after reset.
// - Change flags for CD, DSR and CTS set on any input toggle.
// - Reading modem status clears all four change flags.
// - Bit 7 is inverted CD input, or second user output in loop-back.
// - Bit 6 is inverted RI input, or first user output in loop-back.
// - Bit 5 is inverted DSR input, or DTR control bit in loop-back.
// - Bit 4 is inverted CTS input, or RTS control bit in loop-back.
// - RI change flag sets only on a low to high RI input edge.
// - Modem status interrupt sets while any change flag is set and holds until written to clear.
module ulms_status
  import ulms_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_done_i,
  input wire logic [7:0] rx_char_i,
  input wire logic cd_n_i,
  input wire logic ri_n_i,
  input wire logic dsr_n_i,
  input wire logic cts_n_i,
  output logic dtr_n_o,
  output logic rts_n_o,
  output logic out1_n_o,
  output logic out2_n_o,
  output logic irq_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic overrun;
    logic [3:0] delta;
    logic [3:0] prev;
    logic [4:0] mctl;
    logic [2:0] ists;
    logic [2:0] ien;
    logic [AW:0] count;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [7:0] head;
  } ulms_state_s;

  ulms_state_s st;
  ulms_state_s next_st;
  logic [7:0] fifo_mem [DEPTH];

  // Loop-back aware view of the four modem lines, active high
  function automatic logic [3:0] modem_view(input logic [4:0] mc, input logic [3:0] pins_n);
    logic [3:0] v;
    v = ~pins_n;
    if (mc[`ULMS_MC_LOOP]) begin
      v = {mc[`ULMS_MC_OUT2], mc[`ULMS_MC_OUT1], mc[`ULMS_MC_DTR], mc[`ULMS_MC_RTS]};
    end
    return v;
  endfunction

  // Byte lane 0 write helper
  function automatic logic lane0_wr(input logic [3:0] sel, input logic we, input logic hit);
    return hit & we & sel[0];
  endfunction

  logic access;
  logic rd;
  logic push;
  logic pop;
  logic full;
  logic [3:0] lines;
  logic [7:0] modem_status;
  logic [7:0] line_status;
  logic [3:0] toggled;

  always_comb begin
    access = wb_cyc_i & wb_stb_i & ~st.ack;
    rd = access & ~wb_we_i;
    full = (st.count == (AW + 1)'(DEPTH));
    push = rx_done_i & ~full;
    pop = rd & (wb_adr_i == `ULMS_ADR_RX_DATA) & (st.count != '0);
    lines = modem_view(st.mctl, {cd_n_i, ri_n_i, dsr_n_i, cts_n_i});
    toggled = lines ^ st.prev;
    modem_status = {lines, st.delta};
    line_status = {6'h00, st.overrun, (st.count != '0)};
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.ack = access;
    next_st.prev = lines;
    if (push) begin
      next_st.wptr = st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.rptr = st.rptr + 1'b1;
    end
    next_st.count = st.count + (AW + 1)'(push) - (AW + 1)'(pop);
    next_st.rdat = `ULMS_UNMAPPED_DATA;
    if (rd) begin
      unique case (wb_adr_i)
        `ULMS_ADR_LINE_STATUS: begin
          next_st.rdat = {24'h00_0000, line_status};
          next_st.overrun = 1'b0;
        end
        `ULMS_ADR_MODEM_STATUS: begin
          next_st.rdat = {24'h00_0000, modem_status};
          next_st.delta = 4'h0;
        end
        `ULMS_ADR_MODEM_CONTROL: begin
          next_st.rdat = {27'h000_0000, st.mctl};
        end
        `ULMS_ADR_IRQ_STATUS: begin
          next_st.rdat = {29'h0000_0000, st.ists};
        end
        `ULMS_ADR_IRQ_ENABLE: begin
          next_st.rdat = {29'h0000_0000, st.ien};
        end
        `ULMS_ADR_RX_DATA: begin
          next_st.rdat = {24'h00_0000, st.head};
        end
        default: begin
          next_st.rdat = `ULMS_UNMAPPED_DATA;
        end
      endcase
    end
    if (lane0_wr(wb_sel_i, wb_we_i, access & (wb_adr_i == `ULMS_ADR_MODEM_CONTROL))) begin
      next_st.mctl = wb_dat_i[4:0];
    end
    if (lane0_wr(wb_sel_i, wb_we_i, access & (wb_adr_i == `ULMS_ADR_IRQ_ENABLE))) begin
      next_st.ien = wb_dat_i[2:0];
    end
    if (lane0_wr(wb_sel_i, wb_we_i, access & (wb_adr_i == `ULMS_ADR_IRQ_CLEAR))) begin
      next_st.ists = st.ists & ~wb_dat_i[2:0];
    end
    // Sets after clears so a coincident event is kept
    if (rx_done_i & full) begin
      next_st.overrun = 1'b1;
    end
    next_st.delta[3] = next_st.delta[3] | toggled[3];
    // Ring change only when the pin returns high, so the active-high view falls
    next_st.delta[2] = next_st.delta[2] | (~lines[2] & st.prev[2]);
    next_st.delta[1:0] = next_st.delta[1:0] | toggled[1:0];
    if (|st.delta) begin
      next_st.ists[`ULMS_IRQ_MODEM] = 1'b1;
    end
    if (rx_done_i & full) begin
      next_st.ists[`ULMS_IRQ_OVERRUN] = 1'b1;
    end
    if (push) begin
      next_st.ists[`ULMS_IRQ_READY] = 1'b1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.mctl <= `ULMS_RST_MODEM_CONTROL;
      st.ien <= `ULMS_RST_IRQ_ENABLE;
      st.prev <= 4'h0;
    end else begin
      st <= next_st;
      st.head <= fifo_mem[next_st.rptr];
      // Bypass when the new head is the word written in this very cycle
      if (push & (next_st.rptr == st.wptr)) begin
        st.head <= rx_char_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      fifo_mem[st.wptr] <= rx_char_i;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign irq_o = |(st.ists & st.ien);
  assign dtr_n_o = ~st.mctl[`ULMS_MC_DTR] | st.mctl[`ULMS_MC_LOOP];
  assign rts_n_o = ~st.mctl[`ULMS_MC_RTS] | st.mctl[`ULMS_MC_LOOP];
  assign out1_n_o = ~st.mctl[`ULMS_MC_OUT1] | st.mctl[`ULMS_MC_LOOP];
  assign out2_n_o = ~st.mctl[`ULMS_MC_OUT2] | st.mctl[`ULMS_MC_LOOP];

endmodule

`default_nettype wire

// File: test/ulms_modem_model.sv
/* Modem side model driving the four active low status lines.
   Assumes the bench commands the line levels. */
`timescale 1ns/1ns
`default_nettype none
module ulms_modem_model
  import ulms_pkg::*;
(
  input wire logic clk_i,
  input wire logic [3:0] lines_i,
  output var ulms_modem_in_s pins_o
);
  initial pins_o = 4'hF;
  // Lines move just after a rising edge and idle inactive high
  always @(posedge clk_i) pins_o <= lines_i;
endmodule
`default_nettype wire

// File: test/ulms_status_sva.sv
/* Checker of the status block ports.
   Assumes a bind from the bench top. */
`timescale 1ns/1ns
`default_nettype none
`include "ulms_cfg.svh"
module ulms_status_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dtr_n_o,
  input wire logic rts_n_o,
  input wire logic out1_n_o,
  input wire logic out2_n_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  chk_write_quiet: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000)
    else $error("write returned data");
  chk_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) >= 8'h1C |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_line_upper: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `ULMS_ADR_LINE_STATUS
    |-> wb_dat_o[31:2] == 30'h0000_0000) else $error("line status upper bits set");
  chk_ctrl_drive: assert property (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == `ULMS_ADR_MODEM_CONTROL
    && !$past(wb_dat_i[4]) |-> {out2_n_o, out1_n_o, rts_n_o, dtr_n_o} == ~$past(wb_dat_i[3:0])) else $error("drivers wrong");
  chk_loop_quiet: assert property (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == `ULMS_ADR_MODEM_CONTROL
    && $past(wb_dat_i[4]) |-> {out2_n_o, out1_n_o, rts_n_o, dtr_n_o} == 4'hF) else $error("drivers active in loop");
  chk_irq_masked: assert property (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == `ULMS_ADR_IRQ_ENABLE
    && $past(wb_dat_i[2:0]) == 3'h0 |-> !irq_o) else $error("masked irq high");
  cover property (irq_o);
  cover property (wb_ack_o && $past(wb_adr_i) == `ULMS_ADR_RX_DATA);
  cover property (wb_ack_o && $past(wb_adr_i) == `ULMS_ADR_MODEM_STATUS);
endmodule
`default_nettype wire

// File: test/tb_uart_line_modem_status.sv
/* Bench of the line and modem status block.
   Assumes the modem model and the checker beside it. */
`timescale 1ns/1ns
`default_nettype none
`include "ulms_cfg.svh"
module tb_uart_line_modem_status;
  import ulms_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, rx_done = 1'b0;
  logic [7:0] adr = 8'h00, rx_char = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rdat, rd;
  logic ack, irq, dtr_n, rts_n, out1_n, out2_n;
  logic [3:0] lines = 4'hF;
  ulms_modem_in_s pins;
  int n_fail = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  ulms_modem_model mdl (.clk_i(clk_i), .lines_i(lines), .pins_o(pins));
  ulms_status dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_done_i(rx_done), .rx_char_i(rx_char),
    .cd_n_i(pins.cd_n), .ri_n_i(pins.ri_n), .dsr_n_i(pins.dsr_n), .cts_n_i(pins.cts_n), .dtr_n_o(dtr_n),
    .rts_n_o(rts_n), .out1_n_o(out1_n), .out2_n_o(out2_n), .irq_o(irq));
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Classic cycle: hold until ack, take data at that edge, one idle cycle after
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      summarize();
    end
    @(posedge clk_i);
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] exp, string what);
    bus(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask
  task automatic pin(logic [3:0] v);
    @(posedge clk_i);
    lines <= v;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic push(int n);
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rx_done <= 1'b1;
      rx_char <= 8'(i);
      @(posedge clk_i);
    end
    rx_done <= 1'b0;
  endtask
  task automatic s_rx();
    rdc(`ULMS_ADR_LINE_STATUS, 32'h0000_0000, "ready idle");
    push(1);
    rdc(`ULMS_ADR_LINE_STATUS, 32'h0000_0001, "ready");
    rdc(`ULMS_ADR_RX_DATA, 32'h0000_0000, "char");
    push(33);
    rdc(`ULMS_ADR_LINE_STATUS, 32'h0000_0003, "overrun");
    rdc(`ULMS_ADR_LINE_STATUS, 32'h0000_0001, "overrun read");
    for (int i = 0; i < 32; i++) rdc(`ULMS_ADR_RX_DATA, 32'(i), "fifo kept");
    rdc(`ULMS_ADR_LINE_STATUS, 32'h0000_0000, "drained");
  endtask
  task automatic s_modem();
    rdc(`ULMS_ADR_MODEM_STATUS, 32'h0000_0000, "modem idle");
    rdc(8'h1C, 32'h0000_0000, "unmapped");
    for (int j = 0; j < 4; j++) begin
      pin(~(4'h1 << j));
      rdc(`ULMS_ADR_MODEM_STATUS, (32'h10 << j) | (j == 2 ? 0 : 32'h1 << j), "asserted");
      rdc(`ULMS_ADR_MODEM_STATUS, 32'h10 << j, "read clears");
      pin(4'hF);
      rdc(`ULMS_ADR_MODEM_STATUS, 32'h1 << j, "released");
    end
  endtask
  task automatic s_irq();
    bus(1'b1, `ULMS_ADR_IRQ_CLEAR, 32'h0000_0007);
    bus(1'b1, `ULMS_ADR_IRQ_ENABLE, 32'h0000_0001);
    pin(4'hE);
    check("irq raised", irq, 32'h0000_0001);
    rdc(`ULMS_ADR_MODEM_STATUS, 32'h0000_0011, "cts");
    bus(1'b1, `ULMS_ADR_IRQ_CLEAR, 32'h0000_0001);
    check("irq cleared", irq, 32'h0000_0000);
    bus(1'b1, `ULMS_ADR_IRQ_ENABLE, 32'h0000_0000);
    pin(4'hF);
    check("irq masked", irq, 32'h0000_0000);
    rdc(`ULMS_ADR_IRQ_STATUS, 32'h0000_0001, "masked event");
  endtask
  task automatic s_loop();
    check("drivers idle", {out2_n, out1_n, rts_n, dtr_n}, 32'h0000_000F);
    bus(1'b1, `ULMS_ADR_MODEM_CONTROL, 32'h0000_0005);
    check("drivers", {out2_n, out1_n, rts_n, dtr_n}, 32'h0000_000A);
    bus(1'b1, `ULMS_ADR_MODEM_CONTROL, 32'h0000_001A);
    check("drivers loop", {out2_n, out1_n, rts_n, dtr_n}, 32'h0000_000F);
    bus(1'b0, `ULMS_ADR_MODEM_STATUS, 32'h0000_0000);
    check("loop view", 32'(rd[7:4]), 32'h0000_0009);
    bus(1'b1, `ULMS_ADR_MODEM_CONTROL, 32'h0000_0000);
    rdc(`ULMS_ADR_MODEM_STATUS, 32'h0000_0009, "loop exit");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    s_loop();
    s_rx();
    s_modem();
    s_irq();
    summarize();
  end
endmodule
bind ulms_status ulms_status_sva chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .out1_n_o(out1_n_o), .out2_n_o(out2_n_o), .irq_o(irq_o));
`default_nettype wire
